// ===== rtl/lcd_frame_timing_control.sv
// LCD frame timing and control: AHB-Lite registers, frame/line pulses, polarity alternation
`timescale 1ns/100ps
module lcd_frame_timing_control (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        LF_CLK,
  input  wire logic        TIMER_PAIR_OUT,
  input  wire logic [7:0]  COL_DATA_IN,
  output logic      [7:0]  COL_DATA,
  output logic             DISPLAY_OFF_N,
  output logic             RAM_DRIVER_ADDRESSING,
  output logic             LINE_PULSE,
  output logic             FRAME_START,
  output logic             POLARITY
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage and bus state
  lcd_timing_pkg::control_s ctrl;
  logic [7:0]  period_low;
  logic [7:0]  line_divider;
  logic [7:0]  clock_cfg;
  logic        wr_pend;
  logic [11:0] wr_idx;
  logic [7:0]  rd_data;

  wire         addr_phase = HSEL && HREADY && HTRANS[1];
  wire [11:0]  addr_idx   = HADDR[13:2];
  wire         rd_phase   = addr_phase && !HWRITE;
  wire         wr_ctrl    = wr_pend && (wr_idx == lcd_timing_pkg::IDX_CONTROL);
  wire         wr_low     = wr_pend && (wr_idx == lcd_timing_pkg::IDX_PERIOD_LOW);
  wire         wr_div     = wr_pend && (wr_idx == lcd_timing_pkg::IDX_LINE_DIVIDER);
  wire         wr_cfg     = wr_pend && (wr_idx == lcd_timing_pkg::IDX_CLOCK_CFG);

  ////////////////////////////////////////////////////////////////////////////
  // Timing state
  logic [2:0]  lf_sync;
  logic [2:0]  tmr_sync;
  logic [3:0]  acc;
  logic [9:0]  line_cnt;
  logic [7:0]  div_cnt;

  wire [9:0] frame_period_value = {ctrl.period_bit9, ctrl.period_bit8, period_low};
  wire       running            = ctrl.shift_register_mode;
  wire       timer_sel          = clock_cfg[lcd_timing_pkg::CFG_TIMER_SEL_BIT];
  wire [2:0] commons_code       = clock_cfg[lcd_timing_pkg::CFG_COMMONS_LSB +: 3];

  // Edges taken from second sync stage onward only
  wire lf_rise  = lf_sync[1] && !lf_sync[2];
  wire tmr_rise = tmr_sync[1] && !tmr_sync[2];
  wire src_tick = timer_sel ? tmr_rise : lf_rise;

  logic [3:0] d_half;
  always_comb begin
    unique case (lcd_timing_pkg::commons_e'(commons_code))
      lcd_timing_pkg::COM_128: d_half = lcd_timing_pkg::D_HALF_128;
      lcd_timing_pkg::COM_160: d_half = lcd_timing_pkg::D_HALF_160;
      lcd_timing_pkg::COM_200: d_half = lcd_timing_pkg::D_HALF_200;
      lcd_timing_pkg::COM_240: d_half = lcd_timing_pkg::D_HALF_240;
      lcd_timing_pkg::COM_320: d_half = lcd_timing_pkg::D_HALF_320;
      lcd_timing_pkg::COM_400: d_half = lcd_timing_pkg::D_HALF_400;
      lcd_timing_pkg::COM_480: d_half = lcd_timing_pkg::D_HALF_480;
      default:                 d_half = lcd_timing_pkg::D_HALF_480;
    endcase
  end

  // Half-step accumulator gives fractional D exactly on average
  wire [3:0] acc_step  = acc + lcd_timing_pkg::HALF_STEP;
  wire       line_tick = running && src_tick && (acc_step >= d_half);
  wire [3:0] next_acc  = !running ? 4'h0 :
                         !src_tick ? acc :
                         line_tick ? acc_step - d_half : acc_step;

  // Period below one line is treated as one line so the count never hangs
  wire [9:0] period_m1  = (frame_period_value == 10'h000) ? 10'h000
                                                           : frame_period_value - 10'h001;
  wire       frame_end  = line_tick && (line_cnt >= period_m1);
  wire [9:0] next_line  = !running ? 10'h000 :
                          frame_end ? 10'h000 :
                          line_tick ? line_cnt + 10'h001 : line_cnt;

  wire [7:0] n_m1       = (line_divider == 8'h00) ? 8'h00 : line_divider - 8'h01;
  wire       div_end    = line_tick && (div_cnt >= n_m1);
  wire [7:0] next_div   = !running ? 8'h00 :
                          div_end ? 8'h00 :
                          line_tick ? div_cnt + 8'h01 : div_cnt;

  wire       flip       = ctrl.divided_polarity_enable ? div_end : frame_end;
  wire       next_pol   = !running ? 1'b0 : (POLARITY ^ flip);

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[lcd_timing_pkg::STS_POLARITY_BIT] = POLARITY;
    status[lcd_timing_pkg::STS_RUNNING_BIT]  = running;
  end

  // Read of a register written in the cycle before takes the new value
  wire       fwd       = (wr_ctrl || wr_low || wr_div || wr_cfg) && (wr_idx == addr_idx);
  wire [7:0] next_rd   =
    (addr_idx == lcd_timing_pkg::IDX_STATUS)       ? status :
    fwd                                            ? HWDATA[7:0] :
    (addr_idx == lcd_timing_pkg::IDX_CONTROL)      ? ctrl :
    (addr_idx == lcd_timing_pkg::IDX_PERIOD_LOW)   ? period_low :
    (addr_idx == lcd_timing_pkg::IDX_LINE_DIVIDER) ? line_divider :
    (addr_idx == lcd_timing_pkg::IDX_CLOCK_CFG)    ? clock_cfg : 8'h00;

  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = {24'h000000, rd_data};

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      wr_pend <= 1'b0;
      wr_idx  <= 12'h000;
      rd_data <= 8'h00;
    end else begin
      wr_pend <= addr_phase && HWRITE;
      wr_idx  <= addr_idx;
      if (rd_phase) begin
        rd_data <= next_rd;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ctrl         <= lcd_timing_pkg::RST_CONTROL;
      period_low   <= lcd_timing_pkg::RST_PERIOD_LOW;
      line_divider <= lcd_timing_pkg::RST_LINE_DIVIDER;
      clock_cfg    <= lcd_timing_pkg::RST_CLOCK_CFG;
    end else begin
      if (wr_ctrl) ctrl <= HWDATA[7:0];
      if (wr_low) period_low <= HWDATA[7:0];
      if (wr_div) line_divider <= HWDATA[7:0];
      if (wr_cfg) clock_cfg <= HWDATA[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source clock synchronisers and frame timing
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      lf_sync  <= 3'h0;
      tmr_sync <= 3'h0;
    end else begin
      lf_sync  <= {lf_sync[1:0], LF_CLK};
      tmr_sync <= {tmr_sync[1:0], TIMER_PAIR_OUT};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      acc         <= 4'h0;
      line_cnt    <= 10'h000;
      div_cnt     <= 8'h00;
      LINE_PULSE  <= 1'b0;
      FRAME_START <= 1'b0;
      POLARITY    <= 1'b0;
    end else begin
      acc         <= next_acc;
      line_cnt    <= next_line;
      div_cnt     <= next_div;
      LINE_PULSE  <= line_tick;
      FRAME_START <= frame_end;
      POLARITY    <= next_pol;
    end
  end

  // Column data is registered so blanking and data change on one edge
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      COL_DATA <= 8'h00;
    end else begin
      COL_DATA <= ctrl.blank_columns_bit ? 8'h00 : COL_DATA_IN;
    end
  end

  assign DISPLAY_OFF_N         = ctrl.display_on_bit;
  assign RAM_DRIVER_ADDRESSING = ctrl.ram_driver_addressing;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  sequence s_ctrl_write;
    wr_pend && (wr_idx == lcd_timing_pkg::IDX_CONTROL);
  endsequence

  sequence s_line_then_frame;
    LINE_PULSE && FRAME_START;
  endsequence

  a_display_off_pin: assert property (
    s_ctrl_write |=> DISPLAY_OFF_N == $past(HWDATA[7]))
    else $error("display off pin does not follow control bit 7");

  a_blank_columns: assert property (
    ctrl.blank_columns_bit |=> COL_DATA == 8'h00)
    else $error("column data not blanked");

  a_ram_addressing: assert property (
    s_ctrl_write |=> RAM_DRIVER_ADDRESSING == $past(HWDATA[2]))
    else $error("RAM driver addressing does not follow control bit 2");

  a_stop_quiet: assert property (
    !running |=> !LINE_PULSE && !FRAME_START && !POLARITY)
    else $error("timing output active while stopped");

  a_frame_on_line: assert property (
    FRAME_START |-> s_line_then_frame ##1 !FRAME_START)
    else $error("frame pulse not a single cycle on a line pulse");

  a_frame_period: assert property (
    line_tick && (line_cnt == period_m1) |=> FRAME_START)
    else $error("frame pulse missing after last line");

  a_polarity_frame: assert property (
    !ctrl.divided_polarity_enable && frame_end && running
      |=> POLARITY != $past(POLARITY))
    else $error("polarity did not invert at frame start");

  a_polarity_divided: assert property (
    ctrl.divided_polarity_enable && running && line_tick && !div_end
      |=> POLARITY == $past(POLARITY))
    else $error("polarity inverted before N line pulses");

  a_line_rate_d1: assert property (
    running && src_tick && (d_half == lcd_timing_pkg::D_HALF_400) && $past(running)
      |=> LINE_PULSE)
    else $error("line pulse missing for D of one");

  a_source_select: assert property (
    timer_sel && running && !tmr_rise |=> !LINE_PULSE)
    else $error("line pulse without timer source edge");

  a_polarity_div_flip: assert property (
    ctrl.divided_polarity_enable && running && div_end |=> POLARITY != $past(POLARITY))
    else $error("polarity did not invert after N line pulses");

  a_columns_pass: assert property (
    !ctrl.blank_columns_bit |=> COL_DATA == $past(COL_DATA_IN))
    else $error("column data not passed through");

  a_line_single: assert property (
    LINE_PULSE |=> !LINE_PULSE)
    else $error("line pulse longer than one cycle");

  a_lf_select: assert property (
    !timer_sel && running && !lf_rise |=> !LINE_PULSE)
    else $error("line pulse without low-frequency source edge");

  a_display_hold: assert property (
    !s_ctrl_write |=> $stable(DISPLAY_OFF_N))
    else $error("display off pin changed without a control write");

  a_ram_hold: assert property (
    !s_ctrl_write |=> $stable(RAM_DRIVER_ADDRESSING))
    else $error("RAM addressing changed without a control write");

  a_frame_not_early: assert property (
    line_tick && (line_cnt < period_m1) |=> !FRAME_START)
    else $error("frame pulse before last line");

  a_polarity_frame_hold: assert property (
    !ctrl.divided_polarity_enable && running && !frame_end |=> $stable(POLARITY))
    else $error("polarity changed between frame pulses");

  a_line_needs_source: assert property (
    !src_tick |=> !LINE_PULSE)
    else $error("line pulse without source clock edge");

endmodule // lcd_frame_timing_control

// ===== rtl/lcd_timing_pkg.sv
// Package: register map, field layout and timing tables of the LCD frame timing block
package lcd_timing_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_CLOCK_CFG    = 12'h4B0;
  localparam logic [11:0] IDX_LINE_DIVIDER = 12'h4B1;
  localparam logic [11:0] IDX_STATUS       = 12'h4B2;
  localparam logic [11:0] IDX_CONTROL      = 12'h4B3;
  localparam logic [11:0] IDX_PERIOD_LOW   = 12'h4B4;

  // Reset values
  localparam logic [7:0] RST_CONTROL      = 8'h00;
  localparam logic [7:0] RST_PERIOD_LOW   = 8'h00;
  localparam logic [7:0] RST_LINE_DIVIDER = 8'h00;
  localparam logic [7:0] RST_CLOCK_CFG    = 8'h00;

  // Clock config fields: bit 0 picks the timer, bits 3:1 the common count
  localparam int CFG_TIMER_SEL_BIT = 0;
  localparam int CFG_COMMONS_LSB   = 1;

  // Status fields
  localparam int STS_POLARITY_BIT = 0;
  localparam int STS_RUNNING_BIT  = 1;

  // D in half source-clock steps, per common-count code
  localparam logic [3:0] D_HALF_128  = 4'h6;
  localparam logic [3:0] D_HALF_160  = 4'h5;
  localparam logic [3:0] D_HALF_200  = 4'h4;
  localparam logic [3:0] D_HALF_240  = 4'h3;
  localparam logic [3:0] D_HALF_320  = 4'h3;
  localparam logic [3:0] D_HALF_400  = 4'h2;
  localparam logic [3:0] D_HALF_480  = 4'h2;
  localparam logic [3:0] HALF_STEP   = 4'h2;

  typedef enum logic [2:0] {
    COM_128, COM_160, COM_200, COM_240, COM_320, COM_400, COM_480, COM_UNUSED
  } commons_e;

  // Control register, bit 7 first
  typedef struct packed {
    logic display_on_bit;
    logic blank_columns_bit;
    logic divided_polarity_enable;
    logic spare;
    logic period_bit9;
    logic ram_driver_addressing;
    logic period_bit8;
    logic shift_register_mode;
  } control_s;

endpackage

// ===== verification/lcd_frame_timing_control_tb.sv
// Testbench: register access, blanking and frame timing of the LCD block
`timescale 1ns/100ps
module lcd_frame_timing_control_tb;
  logic        SYS_CLK = 0, RESET = 1, HSEL = 0, HWRITE = 0, LF_CLK = 0, TIMER_PAIR_OUT = 0;
  logic [1:0]  HTRANS = '0;
  logic [2:0]  HSIZE = 3'h2;
  logic [31:0] HADDR = '0, HWDATA = '0, rd;
  logic [7:0]  COL_DATA_IN = 8'h00;
  logic [3:0]  dh [7];
  wire  [31:0] HRDATA;
  wire  [7:0]  COL_DATA;
  wire         ready, HRESP, DISPLAY_OFF_N, RAM_DRIVER_ADDRESSING;
  wire         LINE_PULSE, FRAME_START, POLARITY;
  int          error_cnt = 0, samples_checked = 0, cyc = 0, fl, pl, g2, ln, snap;

  lcd_frame_timing_control uut (.SYS_CLK(SYS_CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(ready),
    .HRDATA(HRDATA), .HREADYOUT(ready), .HRESP(HRESP), .LF_CLK(LF_CLK),
    .TIMER_PAIR_OUT(TIMER_PAIR_OUT), .COL_DATA_IN(COL_DATA_IN), .COL_DATA(COL_DATA),
    .DISPLAY_OFF_N(DISPLAY_OFF_N), .RAM_DRIVER_ADDRESSING(RAM_DRIVER_ADDRESSING),
    .LINE_PULSE(LINE_PULSE), .FRAME_START(FRAME_START), .POLARITY(POLARITY));
  lcd_panel_model panel (.clk(SYS_CLK), .line_pulse(LINE_PULSE), .frame_start(FRAME_START),
    .polarity(POLARITY), .frame_len(fl), .flip_len(pl), .gap2(g2), .lines(ln));

  ////////////////////////////////////////////////////////////////////////////////
  always #2 SYS_CLK = ~SYS_CLK;
  // Source clocks far faster than real, to keep frames short
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    LF_CLK <= (cyc % 10) < 5;
    TIMER_PAIR_OUT <= (cyc % 14) < 7;
    if (cyc == 60000) begin
      error_cnt++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] i, input logic [7:0] d);
    @(posedge SYS_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {18'h0, i, 2'h0};
    do @(posedge SYS_CLK); while (ready !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= {24'h0, d};
    do @(posedge SYS_CLK); while (ready !== 1'b1);
    rd = HRDATA;
    #1;
  endtask
  // Counts one-cycle pulses of frame start or line pulse
  task automatic wt(input bit f, input int n);
    repeat (n) begin
      do @(posedge SYS_CLK); while ((f ? FRAME_START : LINE_PULSE) !== 1'b1);
    end
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    dh = '{lcd_timing_pkg::D_HALF_128, lcd_timing_pkg::D_HALF_160, lcd_timing_pkg::D_HALF_200,
           lcd_timing_pkg::D_HALF_240, lcd_timing_pkg::D_HALF_320, lcd_timing_pkg::D_HALF_400,
           lcd_timing_pkg::D_HALF_480};
    repeat (12) @(posedge SYS_CLK);
    RESET <= 1'b0;
    bus(0, lcd_timing_pkg::IDX_LINE_DIVIDER, 8'h00);
    chk(rd, 32'h0);
    bus(0, lcd_timing_pkg::IDX_CONTROL, 8'h00);
    chk(rd, 32'h0);
    bus(0, lcd_timing_pkg::IDX_PERIOD_LOW, 8'h00);
    chk(rd, 32'h0);
    chk(DISPLAY_OFF_N, 1'b0);
    bus(0, 12'h4B5, 8'h00);
    chk(rd, 32'h0);
    @(posedge SYS_CLK);
    COL_DATA_IN <= 8'hA5;
    bus(1, lcd_timing_pkg::IDX_CONTROL, 8'hC4);
    repeat (2) @(posedge SYS_CLK);
    #1;
    chk(DISPLAY_OFF_N, 1'b1);
    chk(RAM_DRIVER_ADDRESSING, 1'b1);
    chk(COL_DATA, 8'h00);
    bus(1, lcd_timing_pkg::IDX_CONTROL, 8'h80);
    repeat (2) @(posedge SYS_CLK);
    #1;
    chk(COL_DATA, 8'hA5);
    chk(RAM_DRIVER_ADDRESSING, 1'b0);
    // Period 0x205 covers every common count in the table
    bus(1, lcd_timing_pkg::IDX_PERIOD_LOW, 8'h05);
    bus(1, lcd_timing_pkg::IDX_CONTROL, 8'h89);
    for (int c = 0; c < 7; c++) begin
      bus(1, lcd_timing_pkg::IDX_CLOCK_CFG, 8'(c << 1));
      wt(0, 4);
      chk(g2, 32'(dh[c] * 10));
    end
    bus(1, lcd_timing_pkg::IDX_CLOCK_CFG, 8'h0B);
    wt(0, 4);
    chk(g2, 32'd28);
    bus(1, lcd_timing_pkg::IDX_CLOCK_CFG, 8'h0A);
    wt(1, 2);
    chk(fl, 32'd517);
    chk(pl, 32'd517);
    bus(0, lcd_timing_pkg::IDX_STATUS, 8'h00);
    chk(rd[1], 1'b1);
    bus(1, lcd_timing_pkg::IDX_CONTROL, 8'h83);
    bus(1, lcd_timing_pkg::IDX_PERIOD_LOW, 8'h90);
    wt(1, 2);
    chk(fl, 32'd400);
    bus(1, lcd_timing_pkg::IDX_LINE_DIVIDER, 8'h03);
    bus(0, lcd_timing_pkg::IDX_LINE_DIVIDER, 8'h00);
    chk(rd, 32'h3);
    bus(1, lcd_timing_pkg::IDX_CONTROL, 8'hA3);
    wt(0, 10);
    chk(pl, 32'd3);
    bus(1, lcd_timing_pkg::IDX_CONTROL, 8'hA2);
    repeat (5) @(posedge SYS_CLK);
    #1;
    snap = ln;
    repeat (100) @(posedge SYS_CLK);
    #1;
    chk(ln, snap);
    chk(POLARITY, 1'b0);
    bus(0, lcd_timing_pkg::IDX_STATUS, 8'h00);
    chk(rd, 32'h0);
    @(posedge SYS_CLK);
    RESET <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    RESET <= 1'b0;
    bus(0, lcd_timing_pkg::IDX_LINE_DIVIDER, 8'h00);
    chk(rd, 32'h0);
    chk(DISPLAY_OFF_N, 1'b0);
    stop_test();
  end
endmodule // lcd_frame_timing_control_tb

// ===== verification/lcd_panel_model.sv
// Shift-register LCD driver model: measures line, frame and polarity timing
`timescale 1ns/100ps
module lcd_panel_model (
  input  wire logic clk,
  input  wire logic line_pulse,
  input  wire logic frame_start,
  input  wire logic polarity,
  output int        frame_len,
  output int        flip_len,
  output int        gap2,
  output int        lines
);
  int   gap = 0;
  int   prev_gap = 0;
  int   since_frame = 0;
  int   since_flip = 0;
  logic pol_q = 1'b0;
  initial begin
    frame_len = 0;
    flip_len = 0;
    gap2 = 0;
    lines = 0;
  end
  // Two gaps summed, so half-step divisors give a whole figure
  always @(posedge clk) begin
    gap = gap + 1;
    if (line_pulse === 1'b1) begin
      lines = lines + 1;
      since_frame = since_frame + 1;
      since_flip = since_flip + 1;
      gap2 = gap + prev_gap;
      prev_gap = gap;
      gap = 0;
    end
    if (frame_start === 1'b1) begin
      frame_len = since_frame;
      since_frame = 0;
    end
    if (polarity !== pol_q) begin
      flip_len = since_flip;
      since_flip = 0;
    end
    pol_q = polarity;
  end
endmodule // lcd_panel_model
